// ===== hw/amf_consts.svh
// Constants of the authentication message framer: codes, element lengths, frame sizes.
// Assumes inclusion by the parser and framer modules by bare name.
`ifndef AMF_CONSTS_SVH
`define AMF_CONSTS_SVH

// -----------------------------------------------------------------------------
// Message type and element identifier codes
// -----------------------------------------------------------------------------
`define AMF_MSG_REQUEST   8'h40
`define AMF_MSG_REPLY     8'h41
`define AMF_EI_CHALLENGE  8'h0c
`define AMF_EI_RESPONSE   8'h0d
`define AMF_EI_SALT       8'h0e
`define AMF_EI_AUTH_TYPE  8'h0a

// -----------------------------------------------------------------------------
// Element lengths in octets, identifier and length octets included
// -----------------------------------------------------------------------------
`define AMF_LEN_CHALLENGE 10
`define AMF_LEN_SALT      10
`define AMF_LEN_RESPONSE  6
`define AMF_LEN_AUTH_TYPE 5
`define AMF_ELEM_HDR      2

// -----------------------------------------------------------------------------
// Frame sizes in octets
// -----------------------------------------------------------------------------
`define AMF_REQ_OCTETS    26
`define AMF_REPLY_OCTETS  17

`endif

// ===== hw/amf_pkg.sv
// Types shared by the authentication message framer.
// Assumes nothing beyond a SystemVerilog compiler.
package amf_pkg;

  typedef enum logic [1:0] {
    AMF_P_TYPE,
    AMF_P_ID,
    AMF_P_LEN,
    AMF_P_BODY
  } amf_parse_state_t;

  typedef enum logic [1:0] {
    AMF_IDLE,
    AMF_TX_REQUEST,
    AMF_WAIT_REPLY,
    AMF_TX_REPLY
  } amf_state_t;

endpackage

// ===== hw/amf_elem_parser.sv
// Parser for incoming authentication messages, one octet per accepted cycle.
// Assumes the receive stream comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "amf_consts.svh"

module amf_elem_parser
  import amf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  input  wire logic        rxLast,
  output logic             frameDone,
  output logic [7:0]       msgType,
  output logic             gotChallenge,
  output logic             gotResponse,
  output logic             gotSalt,
  output logic [63:0]      challenge,
  output logic [31:0]      response,
  output logic [63:0]      salt
);

  amf_parse_state_t st_reg;
  logic [7:0]       elemId_reg;
  logic [7:0]       remain_reg;

  wire take      = ce && rxValid;
  wire lastOctet = (st_reg == AMF_P_BODY) && (remain_reg == 8'h01);
  wire isChal    = elemId_reg == `AMF_EI_CHALLENGE;
  wire isResp    = elemId_reg == `AMF_EI_RESPONSE;
  wire isSalt    = elemId_reg == `AMF_EI_SALT;

  // -----------------------------------------------------------------------------
  // Framing state
  // -----------------------------------------------------------------------------
  // [R14] Skip foreign elements.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= AMF_P_TYPE;
      elemId_reg <= 8'h00;
      remain_reg <= 8'h00;
      msgType    <= 8'h00;
    end else if (take) begin
      case (st_reg)
        AMF_P_TYPE: begin
          msgType <= rxData;
          st_reg  <= AMF_P_ID;
        end
        AMF_P_ID: begin
          elemId_reg <= rxData;
          st_reg     <= AMF_P_LEN;
        end
        AMF_P_LEN: begin
          remain_reg <= rxData;
          st_reg     <= (rxData == 8'h00) ? AMF_P_ID : AMF_P_BODY;
        end
        default: begin
          remain_reg <= remain_reg - 8'h01;
          if (remain_reg == 8'h01) begin
            st_reg <= AMF_P_ID;
          end
        end
      endcase
      if (rxLast) begin
        st_reg <= AMF_P_TYPE;
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Value capture
  // -----------------------------------------------------------------------------
  // [R8] First octet is most significant.
  // [R9] Last octet carries bit zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      challenge    <= 64'h0;
      response     <= 32'h0;
      salt         <= 64'h0;
      gotChallenge <= 1'b0;
      gotResponse  <= 1'b0;
      gotSalt      <= 1'b0;
      frameDone    <= 1'b0;
    end else if (ce) begin
      frameDone <= take && rxLast;
      if (take && st_reg == AMF_P_TYPE) begin
        gotChallenge <= 1'b0;
        gotResponse  <= 1'b0;
        gotSalt      <= 1'b0;
      end else if (take && st_reg == AMF_P_BODY) begin
        if (isChal) begin
          challenge <= {challenge[55:0], rxData};
        end
        if (isResp) begin
          response <= {response[23:0], rxData};
        end
        if (isSalt) begin
          salt <= {salt[55:0], rxData};
        end
        if (lastOctet && isChal) begin
          gotChallenge <= 1'b1;
        end
        if (lastOctet && isResp) begin
          gotResponse <= 1'b1;
        end
        if (lastOctet && isSalt) begin
          gotSalt <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/amf_fixed_framer.sv
// Fixed-side authentication message framer: builds requests and replies, checks responses.
// Assumes the algorithm block supplies salt, challenge and response values on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "amf_consts.svh"

// Notes on behaviour
// [R1] Message type octets are 0x40 for request and 0x41 for reply, top bit always zero.
// [R2] A portable request holds an authentication type and a challenge with the portable challenge.
// [R3] A fixed request holds an authentication type, a salt and a challenge with the fixed challenge.
// [R4] A response in a portable request appears only in key allocation and then holds the first response.
// [R5] The challenge identifier is 0x0c and the salt identifier is 0x0e.
// [R6] The response identifier is 0x0d and the authentication type identifier is 0x0a.
// [R7] Challenge and salt elements are 10 octets, response 6 and authentication type 5.
// [R8] The top value bit sits in bit 8 of octet 3, right after the length octet.
// [R9] Value bit zero sits in bit 1 of octet 10 for challenge and salt, octet 6 for response.
// [R10] The fixed side gathers salt, challenge and expected response before sending its request.
// [R11] The fixed side compares the returned first response with the expected one and drops on mismatch.
// [R12] On a portable request the fixed side replies with salt and second response.
// [R13] The portable side checks the second response and drops the call on mismatch.
// [R14] Messages with extra unrelated elements are parsed without rejection.
// [R15] First response and its expected value are the leading algorithm output bits.
// [R16] The comparison spans all response bits and gives one pass or fail pulse.
module amf_fixed_framer
  import amf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        startAuthPt,
  input  wire logic [63:0] saltValue,
  input  wire logic [63:0] fixedChallenge,
  input  wire logic [31:0] expectedFirstResponse,
  input  wire logic [23:0] authTypeInfo,
  input  wire logic        secondRespValid,
  input  wire logic [31:0] secondResponse,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  input  wire logic        rxLast,
  output logic [7:0]       txData,
  output logic             txValid,
  output logic             txLast,
  input  wire logic        txReady,
  output logic             authPass,
  output logic             authFail,
  output logic             dropCall,
  output logic             ptChallengeValid,
  output logic [63:0]      ptChallenge,
  output logic             ptKeyAllocResp,
  output logic [31:0]      ptFirstResponse,
  output logic             busy
);

  localparam int FRAME_BITS = 8 * `AMF_REQ_OCTETS;
  localparam int PAD_BITS   = 8 * (`AMF_REQ_OCTETS - `AMF_REPLY_OCTETS);

  amf_state_t             state_reg;
  logic [FRAME_BITS-1:0]  frame_reg;
  logic [4:0]             count_reg;
  logic [31:0]            expected_reg;

  logic                   frameDone;
  logic [7:0]             msgType;
  logic                   gotChallenge;
  logic                   gotResponse;
  logic [63:0]            rxChallenge;
  logic [31:0]            rxResponse;

  // -----------------------------------------------------------------------------
  // Element length octets
  // -----------------------------------------------------------------------------
  // A length octet counts the content only, so identifier and length are taken off.
  // [R7] Content lengths.
  wire [7:0] lenAuthType = 8'(`AMF_LEN_AUTH_TYPE - `AMF_ELEM_HDR);
  wire [7:0] lenSalt     = 8'(`AMF_LEN_SALT - `AMF_ELEM_HDR);
  wire [7:0] lenChal     = 8'(`AMF_LEN_CHALLENGE - `AMF_ELEM_HDR);
  wire [7:0] lenResp     = 8'(`AMF_LEN_RESPONSE - `AMF_ELEM_HDR);

  // -----------------------------------------------------------------------------
  // Frame assembly
  // -----------------------------------------------------------------------------
  // [R1] Request type code.
  // [R3] Fixed request layout.
  // [R5] Challenge and salt identifiers.
  // [R6] Type and response identifiers.
  // [R7] Element lengths.
  // [R8] Value most significant octet first.
  wire [FRAME_BITS-1:0] reqFrame = {
    `AMF_MSG_REQUEST,
    `AMF_EI_AUTH_TYPE, lenAuthType, authTypeInfo,
    `AMF_EI_SALT, lenSalt, saltValue,
    `AMF_EI_CHALLENGE, lenChal, fixedChallenge
  };

  // [R12] Reply with salt and second response.
  // [R1] Reply type code.
  wire [FRAME_BITS-1:0] replyFrame = {
    `AMF_MSG_REPLY,
    `AMF_EI_SALT, lenSalt, saltValue,
    `AMF_EI_RESPONSE, lenResp, secondResponse,
    {PAD_BITS{1'b0}}
  };

  // -----------------------------------------------------------------------------
  // Decode of events
  // -----------------------------------------------------------------------------
  wire idle        = state_reg == AMF_IDLE;
  wire sending     = (state_reg == AMF_TX_REQUEST) || (state_reg == AMF_TX_REPLY);
  wire accept      = sending && txReady;
  wire lastAccept  = accept && (count_reg == 5'd1);
  wire isReply     = frameDone && (msgType == `AMF_MSG_REPLY);
  wire isPtRequest = frameDone && (msgType == `AMF_MSG_REQUEST) && gotChallenge;
  // [R16] Full width comparison.
  wire respMatch   = gotResponse && (rxResponse == expected_reg);
  // A reply with no request outstanding is ignored, so it cannot raise a result.
  wire checkNow    = (state_reg == AMF_WAIT_REPLY) && isReply;
  // A start wins over a reply in one cycle; the caller holds secondRespValid until busy rises.
  wire startReq    = idle && startAuthPt;
  wire startReply  = idle && !startAuthPt && secondRespValid;

  assign txValid = sending;
  assign txLast  = sending && (count_reg == 5'd1);
  assign txData  = frame_reg[FRAME_BITS-1 -: 8];
  assign busy    = !idle;

  // -----------------------------------------------------------------------------
  // Sequence control
  // -----------------------------------------------------------------------------
  // [R10] Values are latched before the request goes out.
  // [R15] Expected first response held for the check.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= AMF_IDLE;
      frame_reg    <= '0;
      count_reg    <= 5'd0;
      expected_reg <= 32'h0;
    end else if (ce) begin
      case (state_reg)
        AMF_IDLE: begin
          if (startReq) begin
            frame_reg    <= reqFrame;
            count_reg    <= 5'(`AMF_REQ_OCTETS);
            expected_reg <= expectedFirstResponse;
            state_reg    <= AMF_TX_REQUEST;
          end else if (startReply) begin
            frame_reg <= replyFrame;
            count_reg <= 5'(`AMF_REPLY_OCTETS);
            state_reg <= AMF_TX_REPLY;
          end
        end
        AMF_WAIT_REPLY: begin
          if (isReply) begin
            state_reg <= AMF_IDLE;
          end
        end
        default: begin
          if (accept) begin
            frame_reg <= {frame_reg[FRAME_BITS-9:0], 8'h00};
            count_reg <= count_reg - 5'd1;
          end
          if (lastAccept) begin
            state_reg <= (state_reg == AMF_TX_REQUEST) ? AMF_WAIT_REPLY : AMF_IDLE;
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------------
  // Check result and portable request report
  // -----------------------------------------------------------------------------
  // A new portable authentication clears a previous drop, so a retried call starts clean.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      authPass         <= 1'b0;
      authFail         <= 1'b0;
      dropCall         <= 1'b0;
      ptChallengeValid <= 1'b0;
      ptChallenge      <= 64'h0;
      ptKeyAllocResp   <= 1'b0;
      ptFirstResponse  <= 32'h0;
    end else if (ce) begin
      // [R16] One pulse per check.
      authPass         <= checkNow && respMatch;
      authFail         <= checkNow && !respMatch;
      ptChallengeValid <= isPtRequest;
      // [R11] Drop the call on mismatch.
      if (checkNow && !respMatch) begin
        dropCall <= 1'b1;
      end else if (startReq) begin
        dropCall <= 1'b0;
      end
      // [R2] Portable challenge taken from request.
      if (isPtRequest) begin
        ptChallenge    <= rxChallenge;
        // [R4] Response only for key allocation.
        ptKeyAllocResp <= gotResponse;
        ptFirstResponse <= rxResponse;
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Receive parser
  // -----------------------------------------------------------------------------
  amf_elem_parser u_parser (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .rxData       (rxData),
    .rxValid      (rxValid),
    .rxLast       (rxLast),
    .frameDone    (frameDone),
    .msgType      (msgType),
    .gotChallenge (gotChallenge),
    .gotResponse  (gotResponse),
    .gotSalt      (),
    .challenge    (rxChallenge),
    .response     (rxResponse),
    .salt         ()
  );

endmodule
`default_nettype wire

// ===== dv/amf_framer_assertions.sv
// Port checks for the fixed-side authentication framer.
// Assumes a bind onto amf_fixed_framer, one clock.
`timescale 1ns/1ps
`default_nettype none
module amf_framer_assertions (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       startAuthPt,
  input wire logic       secondRespValid,
  input wire logic       rxValid,
  input wire logic       rxLast,
  input wire logic [7:0] txData,
  input wire logic       txValid,
  input wire logic       txLast,
  input wire logic       txReady,
  input wire logic       authPass,
  input wire logic       authFail,
  input wire logic       dropCall,
  input wire logic       busy
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_req_open: assert property (!busy && ce && startAuthPt |=> txValid && txData == 8'h40)
    else $error("request does not open with its type octet");
  a_reply_open: assert property (!busy && ce && secondRespValid && !startAuthPt |=> txValid && txData == 8'h41)
    else $error("reply does not open with its type octet");
  a_tx_hold: assert property (txValid && !(txReady && ce) |=> txValid && $stable(txData))
    else $error("octet changed while not accepted");
  a_tx_end: assert property (txLast && txReady && ce |=> !txValid)
    else $error("transmit ran past the last octet");
  a_last_valid: assert property (txLast |-> txValid)
    else $error("last marker without valid octet");
  a_result_late: assert property (authPass || authFail |-> $past(rxValid && rxLast && ce, 2))
    else $error("result pulse not two cycles after frame end");
  a_result_excl: assert property (!(authPass && authFail))
    else $error("pass and fail together");
  a_fail_drop: assert property (authFail |-> ##[0:1] dropCall)
    else $error("fail without dropping the call");
  a_drop_hold: assert property (dropCall && !(startAuthPt && ce && !busy) |=> dropCall)
    else $error("drop released without a new start");
endmodule

bind amf_fixed_framer amf_framer_assertions amf_framer_assertions_inst (
  .clk, .rstn, .ce, .startAuthPt, .secondRespValid, .rxValid, .rxLast, .txData,
  .txValid, .txLast, .txReady, .authPass, .authFail, .dropCall, .busy
);
`default_nettype wire

// ===== dv/amf_peer_model.sv
// Portable-side peer: takes transmitted octets, sends frames on request.
// Assumes the testbench calls send and clr between clock edges.
`timescale 1ns/1ps
`default_nettype none
module amf_peer_model (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       slow,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  input  wire logic       txLast,
  output logic            txReady,
  output logic [7:0]      rxData,
  output logic            rxValid,
  output logic            rxLast
);
  // ---------------------------------------------------------------
  // Receive and send
  // ---------------------------------------------------------------
  logic [7:0] got [0:31];
  int         n;
  int         lastAt;
  initial begin
    txReady = 1'b1;
    rxData = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
    n = 0;
    lastAt = -1;
  end
  // Stalling every other cycle exercises the hold of each octet.
  always @(negedge clk) txReady <= slow ? ~txReady : 1'b1;
  always @(posedge clk) begin
    if (txValid && txReady && ce && n < 32) begin
      got[n] = txData;
      if (txLast) lastAt = n;
      n = n + 1;
    end
  end
  task automatic clr();
    n = 0;
    lastAt = -1;
  endtask
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk);
      rxData = q[i];
      rxValid = 1'b1;
      rxLast = (i == q.size() - 1);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxLast = 1'b0;
    // An idle line carries no stale octet.
    rxData = ~rxData;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Testbench of the fixed-side framer with a portable peer model.
// Assumes the checker is bound to the framer by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import amf_pkg::*;
  logic clk = 0, rstn = 0, ce = 1, slow = 0, startAuthPt = 0, secondRespValid = 0;
  logic [63:0] saltValue = 64'h0123456789abcdef, fixedChallenge = 64'hfedcba9876543210;
  logic [31:0] expectedFirstResponse = 32'h89abcdef, secondResponse = 32'h13579bdf;
  logic [23:0] authTypeInfo = 24'h5a1234;
  logic [7:0]  rxData, txData;
  logic rxValid, rxLast, txValid, txLast, txReady, authPass, authFail, dropCall;
  logic ptChallengeValid, ptKeyAllocResp, busy;
  logic [63:0] ptChallenge;
  logic [31:0] ptFirstResponse;
  logic [7:0]  fr[$];
  int          n_errors = 0, check_count = 0, k;

  always #5 clk = ~clk;

  amf_fixed_framer amf_fixed_framer_inst (.clk(clk), .rstn(rstn), .ce(ce),
    .startAuthPt(startAuthPt), .saltValue(saltValue), .fixedChallenge(fixedChallenge),
    .expectedFirstResponse(expectedFirstResponse), .authTypeInfo(authTypeInfo),
    .secondRespValid(secondRespValid), .secondResponse(secondResponse), .rxData(rxData),
    .rxValid(rxValid), .rxLast(rxLast), .txData(txData), .txValid(txValid), .txLast(txLast),
    .txReady(txReady), .authPass(authPass), .authFail(authFail), .dropCall(dropCall),
    .ptChallengeValid(ptChallengeValid), .ptChallenge(ptChallenge),
    .ptKeyAllocResp(ptKeyAllocResp), .ptFirstResponse(ptFirstResponse), .busy(busy));
  amf_peer_model amf_peer_model_inst (.clk(clk), .ce(ce), .slow(slow), .txData(txData),
    .txValid(txValid), .txLast(txLast), .txReady(txReady), .rxData(rxData),
    .rxValid(rxValid), .rxLast(rxLast));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int lim);
    if (k >= lim) begin
      n_errors++;
      $display("[ERR] wait timed out");
      results();
    end
  endtask
  task automatic p64(input logic [63:0] v);
    for (int i = 7; i >= 0; i--) fr.push_back(v[8*i+:8]);
  endtask
  task automatic p32(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) fr.push_back(v[8*i+:8]);
  endtask
  // Compares the captured transmit frame with fr, octet by octet.
  task automatic txcheck();
    for (k = 0; k < 400 && !(amf_peer_model_inst.n == fr.size() && !txValid); k++) @(negedge clk);
    tmo(400);
    foreach (fr[i]) chk("tx octet", amf_peer_model_inst.got[i], fr[i]);
    chk("last marker", amf_peer_model_inst.lastAt, fr.size() - 1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    chk("idle outputs", {busy, txValid, dropCall, authPass, authFail}, 64'h0);
  endtask
  // Fixed side checks the portable; flip corrupts the lowest response bit, frz stalls the clock enable.
  task automatic s_pt_auth(input logic flip, input logic slw, input logic frz);
    slow = slw;
    amf_peer_model_inst.clr();
    startAuthPt = 1;
    @(negedge clk);
    startAuthPt = 0;
    if (frz) begin
      ce = 0;
      repeat (3) @(negedge clk);
      chk("frozen octet", {txValid, txData, 24'(amf_peer_model_inst.n)}, {1'b1, 8'h40, 24'h0});
      ce = 1;
    end
    fr = {8'h40, 8'h0a, 8'h03};
    fr.push_back(authTypeInfo[23:16]);
    fr.push_back(authTypeInfo[15:8]);
    fr.push_back(authTypeInfo[7:0]);
    fr.push_back(8'h0e);
    fr.push_back(8'h08);
    p64(saltValue);
    fr.push_back(8'h0c);
    fr.push_back(8'h08);
    p64(fixedChallenge);
    txcheck();
    fr = {8'h41, 8'h7b, 8'h02, 8'haa, 8'h55, 8'h0d, 8'h04};
    p32(expectedFirstResponse ^ {31'h0, flip});
    amf_peer_model_inst.send(fr);
    for (k = 0; k < 20 && !(authPass || authFail); k++) @(negedge clk);
    tmo(20);
    chk("pass fail drop", {authPass, authFail, dropCall}, {!flip, flip, flip});
  endtask
  // Portable checks the fixed side; ka adds the key allocation response.
  task automatic s_ft_auth(input logic ka);
    fr = {8'h40, 8'h0a, 8'h03, 8'h11, 8'h22, 8'h33, 8'h0c, 8'h08};
    p64(64'h8000000000000001);
    if (ka) fr = {fr, 8'h0d, 8'h04};
    if (ka) p32(32'h80000001);
    amf_peer_model_inst.send(fr);
    for (k = 0; k < 20 && !ptChallengeValid; k++) @(negedge clk);
    tmo(20);
    chk("peer challenge", ptChallenge, 64'h8000000000000001);
    chk("key alloc flag", ptKeyAllocResp, ka);
    if (ka) chk("first response", ptFirstResponse, 32'h80000001);
    @(negedge clk);
    amf_peer_model_inst.clr();
    secondRespValid = 1;
    @(negedge clk);
    secondRespValid = 0;
    fr = {8'h41, 8'h0e, 8'h08};
    p64(saltValue);
    fr = {fr, 8'h0d, 8'h04};
    p32(secondResponse);
    txcheck();
  endtask

  initial begin
    repeat (6) @(negedge clk);
    s_reset();
    rstn = 1;
    @(negedge clk);
    s_pt_auth(0, 0, 0);
    s_pt_auth(1, 1, 1);
    s_pt_auth(0, 1, 0);
    s_ft_auth(0);
    s_ft_auth(1);
    results();
  end
endmodule
`default_nettype wire
